// [uef_pkg.sv]
/*
  Shared constants and carrier types for the USB endpoint transfer block:
  register offsets, control and status field positions, reset values, PID codes,
  handshake wait timing, and the structs that carry tokens and FIFO controls.
  Assumes a 40 MHz device clock and a packet engine on the same clock.
*/
package uef_pkg;

  localparam int DATA_W = 8;
  localparam int REG_AW = 4;

  // register offsets
  localparam logic [REG_AW-1:0] ADDR_FUNC_ADDR = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_TX_CTRL   = 4'h1;
  localparam logic [REG_AW-1:0] ADDR_RX_CTRL   = 4'h2;
  localparam logic [REG_AW-1:0] ADDR_TX_DATA   = 4'h3;
  localparam logic [REG_AW-1:0] ADDR_RX_DATA   = 4'h4;
  localparam logic [REG_AW-1:0] ADDR_STATUS    = 4'h5;
  localparam logic [REG_AW-1:0] ADDR_COUNT     = 4'h6;

  // fifo control register fields, shared by transmit and receive except commit, which only transmit uses
  localparam int CTL_REWIND_BIT = 0;
  localparam int CTL_ADVANCE_BIT = 1;
  localparam int CTL_AUTO_BIT   = 2;
  localparam int CTL_LOSSY_BIT  = 3;
  localparam int CTL_COMMIT_BIT = 4;
  localparam int CTL_SEQ_BIT    = 7;

  // status register fields, write one to clear
  localparam int ST_TX_DONE  = 0;
  localparam int ST_TX_ACK   = 1;
  localparam int ST_TX_ERR   = 2;
  localparam int ST_RX_DONE  = 3;
  localparam int ST_SOF      = 4;
  localparam int ST_TX_ISO   = 5;
  localparam int ST_RX_ISO   = 6;
  localparam int ST_RX_OVF   = 7;

  // reset values
  localparam logic [7:0] FUNC_ADDR_RST = 8'h00;
  localparam logic       AUTO_RST      = 1'b1;
  localparam logic       LOSSY_RST     = 1'b0;
  localparam logic [7:0] STATUS_RST    = 8'h00;

  // packet identifiers
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_SOF   = 4'h5;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK   = 4'h2;
  localparam logic [3:0] PID_NAK   = 4'hA;

  // longest wait for the host handshake after a data packet
  localparam int HS_WAIT_NS  = 1000;
  localparam int CLK_MHZ     = 40;
  localparam int HS_WAIT_RAW = (HS_WAIT_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] HS_WAIT_CYC = 16'((HS_WAIT_RAW < 1) ? 1 : HS_WAIT_RAW);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_TX_BODY = 2'b01,
    ST_TX_HS   = 2'b10,
    ST_RX_BODY = 2'b11
  } uef_state_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] pid;
    logic [6:0] addr;
    logic [3:0] endp;
  } uef_token_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic wr_commit;
    logic wr_rewind;
    logic rd_commit;
    logic rd_rewind;
  } uef_fifo_ctl_s;

endpackage

// [uef_fifo.sv]
/*
  Packet FIFO with write pointer, write marker, read pointer and read marker.
  Data between read pointer and write marker is readable; a packet is ready when
  the read marker and write marker differ. Controls come from the transfer logic
  on the same clock; only one commit or rewind per side is meaningful per cycle.
*/
`timescale 1ns/1ps
module uef_fifo #(
  parameter int DEPTH_LOG = 6
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire uef_pkg::uef_fifo_ctl_s ctl,
  input  wire logic [7:0]             wr_data,
  output logic      [7:0]             rd_data,
  output logic                        rd_avail,
  output logic                        pkt_ready,
  output logic                        full,
  output logic      [DEPTH_LOG:0]     count
);

  typedef struct packed {
    logic [DEPTH_LOG:0] wp;
    logic [DEPTH_LOG:0] wm;
    logic [DEPTH_LOG:0] rp;
    logic [DEPTH_LOG:0] rm;
  } uef_fifo_state_s;

  localparam logic [DEPTH_LOG:0] DEPTH = (DEPTH_LOG+1)'(1 << DEPTH_LOG);

  logic [7:0]      mem [0:(1<<DEPTH_LOG)-1];
  uef_fifo_state_s q_reg;
  uef_fifo_state_s q_next;

  assign rd_data   = mem[q_reg.rp[DEPTH_LOG-1:0]];
  assign rd_avail  = q_reg.rp != q_reg.wm;
  assign pkt_ready = q_reg.rm != q_reg.wm;
  // space is reckoned against the read marker so a rewind never finds lost data
  assign full      = (q_reg.wp - q_reg.rm) == DEPTH;
  assign count     = q_reg.wm - q_reg.rp;

  always_comb begin
    q_next = q_reg;
    if (ctl.wr_rewind) begin
      q_next.wp = q_reg.wm;
    end else if (ctl.wr && !full) begin
      q_next.wp = q_reg.wp + 1'b1;
    end
    if (ctl.wr_commit) begin
      q_next.wm = q_next.wp;
    end
    if (ctl.rd_rewind) begin
      q_next.rp = q_reg.rm;
    end else if (ctl.rd && rd_avail) begin
      q_next.rp = q_reg.rp + 1'b1;
    end
    if (ctl.rd_commit) begin
      q_next.rm = q_next.rp;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg <= '0;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && ctl.wr && !ctl.wr_rewind && !full) begin
      mem[q_reg.wp[DEPTH_LOG-1:0]] <= wr_data;
    end
  end

endmodule

// [uef_endpoint.sv]
/*
  Transfer sequencing for one USB function endpoint: IN answered from the
  transmit FIFO or, outside isochronous mode, with NAK, OUT written into the receive FIFO, handshakes,
  data toggles, frame-paced isochronous mode and marker management.
  Assumes a packet engine on sys_clk that decodes tokens, delivers received
  bytes with an end strobe and CRC verdict, and serialises outgoing packets.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module uef_endpoint #(
  parameter logic [3:0] ENDPOINT  = 4'h1,
  parameter int         TX_DEPTH_LOG = 6,
  parameter int         RX_DEPTH_LOG = 6
) (
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [uef_pkg::REG_AW-1:0]    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire uef_pkg::uef_token_s           token,
  input  wire logic                          rx_byte_valid,
  input  wire logic [7:0]                    rx_byte,
  input  wire logic                          rx_pkt_end,
  input  wire logic                          rx_pkt_ok,
  input  wire logic [3:0]                    rx_data_pid,
  input  wire logic                          hs_in_valid,
  input  wire logic [3:0]                    hs_in_pid,
  output logic                               tx_pkt_start,
  output logic      [3:0]                    tx_pid,
  output logic                               tx_byte_valid,
  output logic      [7:0]                    tx_byte,
  input  wire logic                          tx_byte_ready,
  output logic                               tx_pkt_end,
  output logic                               hs_out_valid,
  output logic      [3:0]                    hs_out_pid,
  output logic                               tx_done_irq,
  output logic                               rx_done_irq,
  output logic                               sof_irq
);

  typedef struct packed {
    uef_pkg::uef_state_e st;
    logic [6:0]          function_bus_address;
    logic                tx_lossy_select;
    logic                tx_auto_pointer_mode;
    logic                rx_lossy_select;
    logic                rx_auto_pointer_mode;
    logic [7:0]          status;
    logic                tx_seq;
    logic                rx_seq;
    logic                tx_iso_used;
    logic                tx_iso_sent;
    logic                rx_iso_used;
    logic                rx_iso_got;
    logic                rx_discard;
    logic                rx_overflow;
    logic [15:0]         wait_cnt;
    logic [7:0]          rdata;
    logic                tx_start;
    logic [3:0]          tx_pid;
    logic                tx_valid;
    logic [7:0]          tx_byte;
    logic                tx_end;
    logic                hs_valid;
    logic [3:0]          hs_pid;
    logic                txd_irq;
    logic                rxd_irq;
    logic                sof_irq;
  } uef_regs_s;

  uef_regs_s              q_reg;
  uef_regs_s              q_next;
  uef_pkg::uef_fifo_ctl_s txc;
  uef_pkg::uef_fifo_ctl_s rxc;
  logic [7:0]             tx_rd_data;
  logic [7:0]             rx_rd_data;
  logic                   tx_rd_avail;
  logic                   rx_rd_avail;
  logic                   tx_pkt_ready;
  logic                   rx_full;
  logic [TX_DEPTH_LOG:0]  tx_count;
  logic [RX_DEPTH_LOG:0]  rx_count;
  logic                   addr_hit;
  logic                   seq_match;

  // control register readback shows the live sequence bit
  function automatic logic [7:0] ctl_word(input logic seq, input logic lossy,
                                          input logic auto_mode);
    logic [7:0] w;
    w = 8'h00;
    w[uef_pkg::CTL_SEQ_BIT]   = seq;
    w[uef_pkg::CTL_LOSSY_BIT] = lossy;
    w[uef_pkg::CTL_AUTO_BIT]  = auto_mode;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  uef_fifo #(
    .DEPTH_LOG (TX_DEPTH_LOG)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .ctl       (txc),
    .wr_data   (reg_wdata),
    .rd_data   (tx_rd_data),
    .rd_avail  (tx_rd_avail),
    .pkt_ready (tx_pkt_ready),
    .full      (),
    .count     (tx_count)
  );

  uef_fifo #(
    .DEPTH_LOG (RX_DEPTH_LOG)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .ctl       (rxc),
    .wr_data   (rx_byte),
    .rd_data   (rx_rd_data),
    .rd_avail  (rx_rd_avail),
    .pkt_ready (),
    .full      (rx_full),
    .count     (rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign addr_hit  = token.valid && (token.addr == q_reg.function_bus_address)
                     && (token.endp == ENDPOINT);
  assign seq_match = (rx_data_pid == uef_pkg::PID_DATA1) == q_reg.rx_seq;

  always_comb begin
    q_next          = q_reg;
    txc             = '0;
    rxc             = '0;
    q_next.tx_start = 1'b0;
    q_next.tx_end   = 1'b0;
    q_next.hs_valid = 1'b0;
    q_next.txd_irq  = 1'b0;
    q_next.rxd_irq  = 1'b0;
    q_next.sof_irq  = 1'b0;

    // software side: writes and clears first, so hardware sets below win
    if (reg_wr) begin
      if (reg_addr == uef_pkg::ADDR_FUNC_ADDR) begin
        q_next.function_bus_address = reg_wdata[6:0];
      end else if (reg_addr == uef_pkg::ADDR_TX_CTRL) begin
        q_next.tx_lossy_select      = reg_wdata[uef_pkg::CTL_LOSSY_BIT];
        q_next.tx_auto_pointer_mode = reg_wdata[uef_pkg::CTL_AUTO_BIT];
        txc.wr_commit               = reg_wdata[uef_pkg::CTL_COMMIT_BIT];
        if (!q_reg.tx_auto_pointer_mode) begin
          txc.rd_commit = reg_wdata[uef_pkg::CTL_ADVANCE_BIT];
          txc.rd_rewind = reg_wdata[uef_pkg::CTL_REWIND_BIT];
        end
      end else if (reg_addr == uef_pkg::ADDR_RX_CTRL) begin
        q_next.rx_lossy_select      = reg_wdata[uef_pkg::CTL_LOSSY_BIT];
        q_next.rx_auto_pointer_mode = reg_wdata[uef_pkg::CTL_AUTO_BIT];
        if (!q_reg.rx_auto_pointer_mode) begin
          rxc.wr_commit = reg_wdata[uef_pkg::CTL_ADVANCE_BIT];
          rxc.wr_rewind = reg_wdata[uef_pkg::CTL_REWIND_BIT];
        end
      end else if (reg_addr == uef_pkg::ADDR_TX_DATA) begin
        txc.wr = 1'b1;
      end else if (reg_addr == uef_pkg::ADDR_STATUS) begin
        q_next.status = q_reg.status & ~reg_wdata;
      end
    end

    q_next.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == uef_pkg::ADDR_FUNC_ADDR) begin
        q_next.rdata = {1'b0, q_reg.function_bus_address};
      end else if (reg_addr == uef_pkg::ADDR_TX_CTRL) begin
        q_next.rdata = ctl_word(q_reg.tx_seq, q_reg.tx_lossy_select,
                                q_reg.tx_auto_pointer_mode);
      end else if (reg_addr == uef_pkg::ADDR_RX_CTRL) begin
        q_next.rdata = ctl_word(q_reg.rx_seq, q_reg.rx_lossy_select,
                                q_reg.rx_auto_pointer_mode);
      end else if (reg_addr == uef_pkg::ADDR_RX_DATA) begin
        // reads consume for good; freed space becomes visible at once
        q_next.rdata  = rx_rd_data;
        rxc.rd        = rx_rd_avail;
        rxc.rd_commit = rx_rd_avail;
      end else if (reg_addr == uef_pkg::ADDR_STATUS) begin
        q_next.rdata = q_reg.status;
      end else if (reg_addr == uef_pkg::ADDR_COUNT) begin
        q_next.rdata = {4'(tx_count), 4'(rx_count)};
      end
    end

    case (q_reg.st)
      uef_pkg::ST_IDLE: begin
        if (token.valid && token.pid == uef_pkg::PID_SOF) begin
          q_next.sof_irq = 1'b1;
          q_next.status[uef_pkg::ST_SOF] = 1'b1;
          q_next.status[uef_pkg::ST_TX_ISO] = q_reg.tx_iso_sent;
          q_next.status[uef_pkg::ST_RX_ISO] = q_reg.rx_iso_got;
          q_next.tx_iso_used = 1'b0;
          q_next.tx_iso_sent = 1'b0;
          q_next.rx_iso_used = 1'b0;
          q_next.rx_iso_got  = 1'b0;
        end else if (addr_hit && token.pid == uef_pkg::PID_IN) begin
          if (q_reg.tx_lossy_select) begin
            // one iso packet per frame; otherwise stay silent
            if (tx_pkt_ready && !q_reg.tx_iso_used) begin
              q_next.tx_start    = 1'b1;
              q_next.tx_pid      = uef_pkg::PID_DATA0;
              q_next.tx_iso_used = 1'b1;
              q_next.st          = uef_pkg::ST_TX_BODY;
            end
          end else if (tx_pkt_ready) begin
            q_next.tx_start = 1'b1;
            q_next.tx_pid   = q_reg.tx_seq ? uef_pkg::PID_DATA1 : uef_pkg::PID_DATA0;
            q_next.st       = uef_pkg::ST_TX_BODY;
          end else begin
            q_next.hs_valid = 1'b1;
            q_next.hs_pid   = uef_pkg::PID_NAK;
          end
        end else if (addr_hit && token.pid == uef_pkg::PID_OUT) begin
          // second iso packet in a frame is dropped
          q_next.rx_discard  = q_reg.rx_lossy_select && q_reg.rx_iso_used;
          q_next.rx_overflow = 1'b0;
          q_next.st          = uef_pkg::ST_RX_BODY;
        end
      end

      uef_pkg::ST_TX_BODY: begin
        if (!q_reg.tx_valid || tx_byte_ready) begin
          if (tx_rd_avail) begin
            txc.rd          = 1'b1;
            q_next.tx_valid = 1'b1;
            q_next.tx_byte  = tx_rd_data;
          end else begin
            q_next.tx_valid = 1'b0;
            q_next.tx_end   = 1'b1;
            if (q_reg.tx_lossy_select) begin
              // lossy: no handshake wait, data released
              txc.rd_commit      = q_reg.tx_auto_pointer_mode;
              q_next.tx_iso_sent = 1'b1;
              q_next.st          = uef_pkg::ST_IDLE;
            end else begin
              q_next.wait_cnt = uef_pkg::HS_WAIT_CYC;
              q_next.st       = uef_pkg::ST_TX_HS;
            end
          end
        end
      end

      uef_pkg::ST_TX_HS: begin
        // handshake or timeout ends the transfer
        if (hs_in_valid || q_reg.wait_cnt == 16'h0001) begin
          q_next.txd_irq = 1'b1;
          q_next.status[uef_pkg::ST_TX_DONE] = 1'b1;
          q_next.st = uef_pkg::ST_IDLE;
          if (hs_in_valid && hs_in_pid == uef_pkg::PID_ACK) begin
            q_next.tx_seq = ~q_reg.tx_seq;
            txc.rd_commit = q_reg.tx_auto_pointer_mode;
            q_next.status[uef_pkg::ST_TX_ACK] = 1'b1;
          end else begin
            // keep packet for retry
            txc.rd_rewind = q_reg.tx_auto_pointer_mode;
            q_next.status[uef_pkg::ST_TX_ERR] = 1'b1;
          end
        end else begin
          q_next.wait_cnt = q_reg.wait_cnt - 16'h0001;
        end
      end

      uef_pkg::ST_RX_BODY: begin
        if (rx_byte_valid && !q_reg.rx_discard) begin
          if (rx_full) begin
            q_next.rx_overflow = 1'b1;
          end else begin
            rxc.wr = 1'b1;
          end
        end
        if (rx_pkt_end) begin
          q_next.st = uef_pkg::ST_IDLE;
          if (q_reg.rx_lossy_select) begin
            // lossy: no handshake, no done interrupt
            q_next.rx_iso_used = 1'b1;
            if (rx_pkt_ok && !q_reg.rx_discard && !q_reg.rx_overflow) begin
              rxc.wr_commit     = q_reg.rx_auto_pointer_mode;
              q_next.rx_iso_got = 1'b1;
            end else begin
              rxc.wr_rewind = q_reg.rx_auto_pointer_mode;
            end
          end else if (!rx_pkt_ok) begin
            // corrupt packet: silence lets the host retry
            rxc.wr_rewind = q_reg.rx_auto_pointer_mode;
          end else if (q_reg.rx_overflow) begin
            rxc.wr_rewind   = q_reg.rx_auto_pointer_mode;
            q_next.hs_valid = 1'b1;
            q_next.hs_pid   = uef_pkg::PID_NAK;
            q_next.status[uef_pkg::ST_RX_OVF] = 1'b1;
          end else if (seq_match) begin
            rxc.wr_commit   = q_reg.rx_auto_pointer_mode;
            q_next.rx_seq   = ~q_reg.rx_seq;
            q_next.hs_valid = 1'b1;
            q_next.hs_pid   = uef_pkg::PID_ACK;
            q_next.rxd_irq  = 1'b1;
            q_next.status[uef_pkg::ST_RX_DONE] = 1'b1;
          end else begin
            rxc.wr_rewind   = q_reg.rx_auto_pointer_mode;
            q_next.hs_valid = 1'b1;
            q_next.hs_pid   = uef_pkg::PID_ACK;
          end
        end
      end

      default: begin
        q_next.st = uef_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg                      <= '0;
      q_reg.st                   <= uef_pkg::ST_IDLE;
      q_reg.function_bus_address <= uef_pkg::FUNC_ADDR_RST[6:0];
      q_reg.tx_auto_pointer_mode <= uef_pkg::AUTO_RST;
      q_reg.rx_auto_pointer_mode <= uef_pkg::AUTO_RST;
      q_reg.tx_lossy_select      <= uef_pkg::LOSSY_RST;
      q_reg.rx_lossy_select      <= uef_pkg::LOSSY_RST;
      q_reg.status               <= uef_pkg::STATUS_RST;
      q_reg.tx_pid               <= uef_pkg::PID_DATA0;
      q_reg.hs_pid               <= uef_pkg::PID_NAK;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  assign reg_rdata     = q_reg.rdata;
  assign tx_pkt_start  = q_reg.tx_start;
  assign tx_pid        = q_reg.tx_pid;
  assign tx_byte_valid = q_reg.tx_valid;
  assign tx_byte       = q_reg.tx_byte;
  assign tx_pkt_end    = q_reg.tx_end;
  assign hs_out_valid  = q_reg.hs_valid;
  assign hs_out_pid    = q_reg.hs_pid;
  assign tx_done_irq   = q_reg.txd_irq;
  assign rx_done_irq   = q_reg.rxd_irq;
  assign sof_irq       = q_reg.sof_irq;

endmodule

// [uef_endpoint_assertions.sv]
/* port checks for the endpoint transfer block.
   assumes clk_en held high by the bench. */
`timescale 1ns/1ps
module uef_endpoint_assertions (
  input wire logic                sys_clk,
  input wire logic                reset,
  input wire uef_pkg::uef_token_s token,
  input wire logic                rx_pkt_end,
  input wire logic                rx_pkt_ok,
  input wire logic                tx_pkt_start,
  input wire logic [3:0]          tx_pid,
  input wire logic                tx_byte_valid,
  input wire logic [7:0]          tx_byte,
  input wire logic                tx_byte_ready,
  input wire logic                hs_out_valid,
  input wire logic [3:0]          hs_out_pid,
  input wire logic                rx_done_irq,
  input wire logic                sof_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // foreign IN tokens, and lossy ones with no packet ready or after the frame's packet, go unanswered, so only the cause is checked
  a_sof_cause: assert property (sof_irq |-> $past(token.valid && token.pid == uef_pkg::PID_SOF))
    else $error("sof pulse without token");
  a_start_cause: assert property (
    tx_pkt_start |-> $past(token.valid && token.pid == uef_pkg::PID_IN))
    else $error("data start without in token");
  a_start_byte: assert property (tx_pkt_start |=> tx_byte_valid)
    else $error("no byte after start");
  a_byte_hold: assert property (tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte))
    else $error("byte dropped while stalled");
  a_rx_done_ack: assert property (rx_done_irq |-> hs_out_valid && hs_out_pid == uef_pkg::PID_ACK)
    else $error("rx done without ack");
  a_rx_done_ok: assert property (rx_done_irq |-> $past(rx_pkt_end && rx_pkt_ok))
    else $error("rx done without good packet");
  a_nak_cause: assert property (hs_out_valid && hs_out_pid == uef_pkg::PID_NAK |-> $past(token.valid) || $past(rx_pkt_end))
    else $error("nak without cause");
  a_pid_held: assert property (tx_byte_valid && $past(tx_byte_valid) |-> $stable(tx_pid))
    else $error("data pid changed in packet");
endmodule
bind uef_endpoint uef_endpoint_assertions chk_inst (.sys_clk, .reset, .token, .rx_pkt_end,
  .rx_pkt_ok, .tx_pkt_start, .tx_pid, .tx_byte_valid, .tx_byte, .tx_byte_ready,
  .hs_out_valid, .hs_out_pid, .rx_done_irq, .sof_irq);

// [uef_host_model.sv]
/* host side model: tokens, out data, handshakes.
   assumes tasks start right after a clock edge. */
`timescale 1ns/1ps
module uef_host_model (
  input  wire logic           sys_clk,
  input  wire logic           tx_byte_valid,
  input  wire logic [7:0]     tx_byte,
  output uef_pkg::uef_token_s token,
  output logic                rx_byte_valid,
  output logic [7:0]          rx_byte,
  output logic                rx_pkt_end,
  output logic                rx_pkt_ok,
  output logic [3:0]          rx_data_pid,
  output logic                hs_in_valid,
  output logic [3:0]          hs_in_pid,
  output logic                tx_byte_ready
);
  logic [7:0] got [$];
  initial {token, rx_byte_valid, rx_byte, rx_pkt_end, rx_pkt_ok, rx_data_pid} = '0;
  initial {hs_in_valid, hs_in_pid, tx_byte_ready} = '0;
  // stall every other cycle, slow and prompt alike
  always @(posedge sys_clk) tx_byte_ready <= ~tx_byte_ready;
  always @(posedge sys_clk) if (tx_byte_valid && tx_byte_ready) got.push_back(tx_byte);
  task automatic tok(input logic [3:0] pid, input logic [6:0] adr);
    token <= '{1'b1, pid, adr, 4'h1};
    @(posedge sys_clk);
    token <= '{1'b0, ~pid, ~adr, 4'h0};
  endtask
  task automatic out_pkt(input logic [3:0] dpid, input int n);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'(8'hA0 + i);
      @(posedge sys_clk);
    end
    {rx_byte_valid, rx_pkt_end, rx_pkt_ok, rx_data_pid} <= {2'b01, 1'b1, dpid};
    @(posedge sys_clk);
    {rx_pkt_end, rx_pkt_ok, rx_data_pid, rx_byte} <= {2'b00, ~dpid, ~rx_byte};
  endtask
  task automatic hs(input logic [3:0] pid);
    {hs_in_valid, hs_in_pid} <= {1'b1, pid};
    @(posedge sys_clk);
    {hs_in_valid, hs_in_pid} <= {1'b0, ~pid};
  endtask
endmodule

// [usb_endpoint_fifo_transfer_tb.sv]
/* bench for the endpoint transfer block.
   assumes the host model and checker files compile first. */
`timescale 1ns/1ps
module usb_endpoint_fifo_transfer_tb;
  logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, tx_byte;
  logic [3:0] tx_pid, hs_out_pid, rx_data_pid, hs_in_pid;
  logic tx_pkt_start, tx_byte_valid, tx_pkt_end, hs_out_valid, tx_done_irq, rx_done_irq;
  logic sof_irq, rx_byte_valid, rx_pkt_end, rx_pkt_ok, hs_in_valid, tx_byte_ready;
  logic [7:0] rx_byte;
  uef_pkg::uef_token_s token;
  int n_mismatch = 0, n_compared = 0;
  int ev [6] = '{default: 0};
  initial forever #12.5 sys_clk = ~sys_clk;
  uef_endpoint uef_endpoint_inst (.sys_clk, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .token, .rx_byte_valid, .rx_byte, .rx_pkt_end, .rx_pkt_ok,
    .rx_data_pid, .hs_in_valid, .hs_in_pid, .tx_pkt_start, .tx_pid, .tx_byte_valid, .tx_byte,
    .tx_byte_ready, .tx_pkt_end, .hs_out_valid, .hs_out_pid, .tx_done_irq, .rx_done_irq,
    .sof_irq);
  uef_host_model uef_host_model_inst (.sys_clk, .tx_byte_valid, .tx_byte, .token,
    .rx_byte_valid, .rx_byte, .rx_pkt_end, .rx_pkt_ok, .rx_data_pid, .hs_in_valid, .hs_in_pid,
    .tx_byte_ready);
  // pulse counters: packet end, tx done, rx done, sof, ack out, nak out
  always @(posedge sys_clk) begin
    ev[0] += int'(tx_pkt_end === 1'b1);
    ev[1] += int'(tx_done_irq === 1'b1);
    ev[2] += int'(rx_done_irq === 1'b1);
    ev[3] += int'(sof_irq === 1'b1);
    ev[4] += int'(hs_out_valid === 1'b1 && hs_out_pid === uef_pkg::PID_ACK);
    ev[5] += int'(hs_out_valid === 1'b1 && hs_out_pid === uef_pkg::PID_NAK);
  end
  ////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk) chk(reg_rdata, e);
    @(posedge sys_clk);
  endtask
  // bounded wait for a pulse count; running out ends the run
  task automatic wt(input int i, input int n);
    for (int k = 0; k < 200 && ev[i] < n; k++) @(negedge sys_clk);
    chk(8'(ev[i]), 8'(n));
    if (ev[i] < n) stop_test();
    // back on the rising edge so the host model drives right after it
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd(uef_pkg::ADDR_FUNC_ADDR, 8'h00); // address resets to zero
    rd(uef_pkg::ADDR_TX_CTRL, 8'h04); // mode bits at reset
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h00);
    wt(5, 1); // nak with empty fifo
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h05);
    repeat (20) @(posedge sys_clk);
    chk(8'(ev[5] + ev[0]), 8'd1); // foreign address ignored
    wr(uef_pkg::ADDR_TX_DATA, 8'h11); // load before the in
    wr(uef_pkg::ADDR_TX_DATA, 8'h22);
    wr(uef_pkg::ADDR_TX_CTRL, 8'h14);
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h00);
    wt(0, 1);
    chk(uef_host_model_inst.got[0], 8'h11); // bytes in order
    chk(uef_host_model_inst.got[1], 8'h22); // bytes in order
    uef_host_model_inst.hs(uef_pkg::PID_ACK);
    wt(1, 1); // done after ack
    rd(uef_pkg::ADDR_STATUS, 8'h03); // done with ack flag
    rd(uef_pkg::ADDR_TX_CTRL, 8'h84); // toggle on ack
    wr(uef_pkg::ADDR_STATUS, 8'hFF);
    wr(uef_pkg::ADDR_TX_DATA, 8'h33);
    wr(uef_pkg::ADDR_TX_CTRL, 8'h14);
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h00);
    wt(1, 2); // done even without handshake
    chk(8'(tx_pid), 8'(uef_pkg::PID_DATA1)); // toggled data pid sent
    rd(uef_pkg::ADDR_STATUS, 8'h05); // error flag set
    rd(uef_pkg::ADDR_TX_CTRL, 8'h84); // no toggle on timeout
    uef_host_model_inst.tok(uef_pkg::PID_OUT, 7'h00);
    uef_host_model_inst.out_pkt(uef_pkg::PID_DATA0, 2);
    wt(2, 1); // ack and rx done
    rd(uef_pkg::ADDR_RX_DATA, 8'hA0); // data in rx fifo
    rd(uef_pkg::ADDR_RX_DATA, 8'hA1); // data in rx fifo
    uef_host_model_inst.tok(uef_pkg::PID_OUT, 7'h00);
    uef_host_model_inst.out_pkt(uef_pkg::PID_DATA0, 1);
    wt(4, 2); // duplicate still acked
    chk(8'(ev[2]), 8'd1); // duplicate not signalled
    uef_host_model_inst.tok(uef_pkg::PID_SOF, 7'h33);
    wt(3, 1); // sof pulse
    wr(uef_pkg::ADDR_STATUS, 8'hFF);
    wr(uef_pkg::ADDR_RX_CTRL, 8'h0C); // isochronous rx
    uef_host_model_inst.tok(uef_pkg::PID_OUT, 7'h00);
    uef_host_model_inst.out_pkt(uef_pkg::PID_DATA1, 1);
    repeat (30) @(posedge sys_clk);
    chk(8'(ev[4] + ev[2]), 8'd3); // no handshake or done
    uef_host_model_inst.tok(uef_pkg::PID_SOF, 7'h00);
    wt(3, 2);
    rd(uef_pkg::ADDR_STATUS, 8'h50); // status at next sof
    wr(uef_pkg::ADDR_TX_CTRL, 8'h0C); // isochronous tx
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h00);
    wt(0, 3); // lossy packet sent
    chk(uef_host_model_inst.got[3], 8'h33); // retained packet resent
    uef_host_model_inst.tok(uef_pkg::PID_IN, 7'h00);
    repeat (30) @(posedge sys_clk);
    chk(8'(ev[0] * 4 + ev[1] + ev[5]), 8'd15); // one per frame, no done
    uef_host_model_inst.tok(uef_pkg::PID_SOF, 7'h00);
    wt(3, 3);
    rd(uef_pkg::ADDR_STATUS, 8'h30); // tx status at frame end
    stop_test();
  end
endmodule
